// *** rtl/drss_sequencer.sv ***
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "drss_defines.svh"

// How it works
// R1: quick-halt permit low ramps speed to zero
// R2: quick-halt latched, no restart before ramp done
// R3: freewheel permit low disables power stage
// R4: freewheel latched, no restart before coast done
// R5: direction invert flips remote setpoint direction
// R6: fault clear rising edge clears latched trips
// R7: optional run rising edge clears trips
// R8: autostart runs at power-up if run present
// R9: drive-ok drops on trip, returns without run
// R10: run accepted waits contactor and deflux
// R11: stack-ready only when drive would run
// R12: reset pulse of one execution cycle entering run or jog
// R13: state code 0 to 7, resets to 0
// R14: direction output shows demanded direction
// R15: fan on while hot, held 60 s after
// R16: run_accepted_flag closes contactor, starts delay timer
// R17: no feedback before timeout raises contactor trip
// R18: status flags all false after reset, except drive-ok which resets true
// R19: commands acted on only when permitted
// R20: forward and reverse together means stop
// R21: contactor feedback reports real closure
// R22: sequencer state and latches update once per execution cycle
module drss_sequencer
#(
    parameter int TICK_CYCLES = `DRSS_TICK_CYCLES,
    parameter int FAN_HOLD_TICKS = `DRSS_FAN_HOLD_TICKS,
    parameter int TICKS_PER_TENTH = `DRSS_TICKS_PER_TENTH
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire drss_pkg::drss_plant_type plant,
    output logic contactor_drive,
    output logic stage_enable,
    output logic fast_halt_ramp,
    output logic system_reset_pulse,
    output logic direction_demand_out,
    output logic cooling_fan_request,
    output logic [2:0] seq_state
);
    import drss_pkg::*;

    localparam int TW = `DRSS_TMR_WIDTH;

    function automatic logic [TW-1:0] to_tmr(input int value);
        to_tmr = TW'(value);
    endfunction

    // APB
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    drss_cmd_type cmd_ff;
    logic [`DRSS_DELAY_WIDTH-1:0] delay_ff;

    wire setup_phase = psel & ~penable;
    wire wr_now = psel & penable & pready_ff & pwrite;
    wire sel_cmd = (paddr == `DRSS_OFS_CMD);
    wire sel_delay = (paddr == `DRSS_OFS_DELAY);
    wire sel_status = (paddr == `DRSS_OFS_STATUS);
    wire mapped = sel_cmd | sel_delay | sel_status;
    wire bad_wr = pwrite & sel_status;
    wire [`DRSS_DELAY_WIDTH-1:0] wr_delay = pwdata[`DRSS_DELAY_WIDTH-1:0];
    // Below one second is not allowed, so writes are clamped
    wire [`DRSS_DELAY_WIDTH-1:0] clamped_delay =
        (wr_delay < `DRSS_DELAY_MIN) ? `DRSS_DELAY_MIN :
        (wr_delay > `DRSS_DELAY_MAX) ? `DRSS_DELAY_MAX : wr_delay; // R16

    // Execution cycle tick
    logic [TW-1:0] tick_cnt_ff;
    logic tick_ff;
    wire tick_wrap = (tick_cnt_ff == to_tmr(TICK_CYCLES - 1));

    // Sequencer state
    drss_state_type state_ff;
    drss_state_type nxt_state;
    logic run_prev_ff;
    logic clr_prev_ff;
    logic first_tick_ff;
    logic qhalt_latch_ff;
    logic coast_latch_ff;
    logic trip_latch_ff;
    logic drive_ok_ff;
    logic jogging_ff;
    logic con_fault_ff;
    logic [TW-1:0] con_tmr_ff;
    logic [TW-1:0] fan_tmr_ff;
    logic sys_rst_ff;
    logic stage_en_ff;
    logic contactor_ff;
    logic halt_ramp_ff;
    logic dir_ff;
    logic fan_ff;
    logic halt_in_progress_flag_ff;
    logic stack_ready_ff;

    wire fwd_only = cmd_ff.run_fwd & ~cmd_ff.run_rev; // R20
    wire rev_only = cmd_ff.run_rev & ~cmd_ff.run_fwd; // R20
    wire run_req = cmd_ff.remote_sel & (fwd_only | rev_only | cmd_ff.jog); // R19
    wire permits_ok = cmd_ff.power_enable & cmd_ff.quick_halt_permit
        & cmd_ff.freewheel_permit & drive_ok_ff & cmd_ff.remote_sel; // R19
    // Edges are against the value seen on the previous execution cycle
    wire run_rise = run_req & ~run_prev_ff; // R22
    wire clr_rise = cmd_ff.remote_fault_clear & ~clr_prev_ff; // R6
    wire fault_clear = clr_rise
        | (cmd_ff.clear_faults_on_run_edge & run_rise); // R6 R7
    wire run_go = run_rise | (cmd_ff.autostart & first_tick_ff & run_req); // R8
    wire con_timeout = (state_ff == DRSS_RUN_ACCEPTED_FLAG) && (con_tmr_ff == '0)
        && !plant.contactor_closed; // R17
    wire tripping = plant.stack_trip | con_timeout;
    wire in_fault = (state_ff == DRSS_FAULT_ACTIVE) || (state_ff == DRSS_FAULTED);
    wire restart_blocked = qhalt_latch_ff | coast_latch_ff | trip_latch_ff; // R2 R4
    wire hot = plant.heatsink_hot | plant.ambient_hot | plant.load_high;
    wire entering_run = (nxt_state == DRSS_ENABLED) && (state_ff != DRSS_ENABLED);
    wire [TW-1:0] con_load = TW'(delay_ff) * to_tmr(TICKS_PER_TENTH); // R16

    always_comb
    begin
        nxt_state = state_ff;
        if (tripping && !in_fault)
        begin
            nxt_state = DRSS_FAULT_ACTIVE;
        end
        else
        begin
            unique case (state_ff)
                DRSS_START_DISABLED:
                    if (permits_ok && !restart_blocked)
                    begin
                        nxt_state = DRSS_START_ENABLED;
                    end
                DRSS_START_ENABLED:
                    if (!permits_ok || restart_blocked)
                    begin
                        nxt_state = DRSS_START_DISABLED;
                    end
                    else if (run_go)
                    begin
                        nxt_state = DRSS_RUN_ACCEPTED_FLAG; // R10
                    end
                DRSS_RUN_ACCEPTED_FLAG:
                    if (!permits_ok || !run_req)
                    begin
                        nxt_state = DRSS_START_DISABLED;
                    end
                    else if (plant.contactor_closed && plant.deflux_done)
                    begin
                        nxt_state = DRSS_READY; // R10 R17 R21
                    end
                DRSS_READY:
                    if (permits_ok && run_req)
                    begin
                        nxt_state = DRSS_ENABLED;
                    end
                    else
                    begin
                        nxt_state = DRSS_START_DISABLED;
                    end
                DRSS_ENABLED:
                    if (!cmd_ff.quick_halt_permit)
                    begin
                        nxt_state = DRSS_QHALT_ACTIVE; // R1
                    end
                    else if (!cmd_ff.freewheel_permit || !cmd_ff.power_enable)
                    begin
                        nxt_state = DRSS_START_DISABLED; // R3
                    end
                    else if (!run_req && plant.halt_ramp_done)
                    begin
                        nxt_state = DRSS_START_DISABLED;
                    end
                DRSS_QHALT_ACTIVE:
                    if (plant.halt_ramp_done)
                    begin
                        nxt_state = DRSS_START_DISABLED; // R2
                    end
                DRSS_FAULT_ACTIVE:
                    nxt_state = DRSS_FAULTED;
                DRSS_FAULTED:
                    if (fault_clear)
                    begin
                        nxt_state = DRSS_START_DISABLED; // R6 R7
                    end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            cmd_ff <= drss_cmd_type'(`DRSS_CMD_RESET);
            delay_ff <= `DRSS_DELAY_DEFAULT;
        end
        else
        begin
            // No wait state: answer is registered in the setup cycle
            pready_ff <= setup_phase;
            pslverr_ff <= setup_phase & (~mapped | bad_wr);
            if (setup_phase)
            begin
                prdata_ff <= 32'h0000_0000;
                if (!pwrite && sel_cmd)
                begin
                    prdata_ff <= 32'(cmd_ff);
                end
                else if (!pwrite && sel_delay)
                begin
                    prdata_ff <= 32'(delay_ff);
                end
                else if (!pwrite && sel_status)
                begin
                    prdata_ff <= 32'({con_fault_ff, fan_ff, dir_ff, contactor_ff,
                        state_ff == DRSS_START_ENABLED, stack_ready_ff,
                        state_ff == DRSS_RUN_ACCEPTED_FLAG, drive_ok_ff, trip_latch_ff,
                        halt_in_progress_flag_ff, jogging_ff, stage_en_ff, state_ff}); // R18
                end
            end
            if (wr_now && sel_cmd)
            begin
                cmd_ff <= drss_cmd_type'(pwdata[`DRSS_CMD_WIDTH-1:0]);
            end
            if (wr_now && sel_delay)
            begin
                delay_ff <= clamped_delay;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_cnt_ff <= tick_wrap ? '0 : tick_cnt_ff + to_tmr(1);
            tick_ff <= tick_wrap; // R22
        end
    end

    // All sequencer state moves only on the execution tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= DRSS_START_DISABLED; // R13
            run_prev_ff <= 1'b0;
            clr_prev_ff <= 1'b0;
            first_tick_ff <= 1'b1;
            qhalt_latch_ff <= 1'b0;
            coast_latch_ff <= 1'b0;
            trip_latch_ff <= 1'b0;
            drive_ok_ff <= 1'b1;
            jogging_ff <= 1'b0;
            con_fault_ff <= 1'b0;
            con_tmr_ff <= '0;
            sys_rst_ff <= 1'b0;
        end
        else if (tick_ff)
        begin
            state_ff <= nxt_state;
            run_prev_ff <= run_req; // R22
            clr_prev_ff <= cmd_ff.remote_fault_clear; // R22
            first_tick_ff <= first_tick_ff & (state_ff == DRSS_START_DISABLED); // R8
            sys_rst_ff <= entering_run; // R12
            // Quick halt is held until the ramp has truly reached zero
            if (!cmd_ff.quick_halt_permit && (state_ff == DRSS_ENABLED))
            begin
                qhalt_latch_ff <= 1'b1; // R2
            end
            else if (plant.halt_ramp_done && cmd_ff.quick_halt_permit)
            begin
                qhalt_latch_ff <= 1'b0;
            end
            if (!cmd_ff.freewheel_permit)
            begin
                coast_latch_ff <= 1'b1; // R4
            end
            else if (plant.coast_done)
            begin
                coast_latch_ff <= 1'b0;
            end
            // Set beats clear on the same tick
            if (tripping)
            begin
                trip_latch_ff <= 1'b1;
            end
            else if (fault_clear)
            begin
                trip_latch_ff <= 1'b0; // R6 R7
            end
            if (con_timeout)
            begin
                con_fault_ff <= 1'b1; // R17
            end
            else if (fault_clear)
            begin
                con_fault_ff <= 1'b0;
            end
            if (tripping)
            begin
                drive_ok_ff <= 1'b0; // R9
            end
            else if (!run_req)
            begin
                drive_ok_ff <= 1'b1; // R9
            end
            if (entering_run)
            begin
                jogging_ff <= cmd_ff.jog & ~fwd_only & ~rev_only;
            end
            else if (nxt_state != DRSS_ENABLED)
            begin
                jogging_ff <= 1'b0;
            end
            if (nxt_state == DRSS_RUN_ACCEPTED_FLAG && state_ff != DRSS_RUN_ACCEPTED_FLAG)
            begin
                con_tmr_ff <= con_load; // R16
            end
            else if (con_tmr_ff != '0)
            begin
                con_tmr_ff <= con_tmr_ff - to_tmr(1);
            end
        end
    end

    // Output flops load every clock from the state, the command register and the plant inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage_en_ff <= 1'b0;
            contactor_ff <= 1'b0;
            halt_ramp_ff <= 1'b0;
            dir_ff <= 1'b0;
            fan_ff <= 1'b0;
            fan_tmr_ff <= '0;
            halt_in_progress_flag_ff <= 1'b0;
            stack_ready_ff <= 1'b0;
        end
        else
        begin
            stage_en_ff <= ((state_ff == DRSS_ENABLED) || (state_ff == DRSS_QHALT_ACTIVE))
                & ~coast_latch_ff & cmd_ff.freewheel_permit & cmd_ff.power_enable; // R3
            contactor_ff <= (state_ff == DRSS_RUN_ACCEPTED_FLAG) || (state_ff == DRSS_READY)
                || (state_ff == DRSS_ENABLED) || (state_ff == DRSS_QHALT_ACTIVE); // R16
            halt_ramp_ff <= (state_ff == DRSS_QHALT_ACTIVE); // R1
            dir_ff <= cmd_ff.dir_invert ^ rev_only; // R5 R14
            halt_in_progress_flag_ff <= (state_ff == DRSS_QHALT_ACTIVE) || coast_latch_ff
                || ((state_ff == DRSS_ENABLED) && !run_req);
            stack_ready_ff <= (state_ff == DRSS_READY); // R11
            if (tick_ff)
            begin
                if (hot)
                begin
                    fan_tmr_ff <= to_tmr(FAN_HOLD_TICKS); // R15
                end
                else if (fan_tmr_ff != '0)
                begin
                    fan_tmr_ff <= fan_tmr_ff - to_tmr(1);
                end
            end
            fan_ff <= hot | (fan_tmr_ff != '0); // R15
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign contactor_drive = contactor_ff;
    assign stage_enable = stage_en_ff;
    assign fast_halt_ramp = halt_ramp_ff;
    assign system_reset_pulse = sys_rst_ff;
    assign direction_demand_out = dir_ff;
    assign cooling_fan_request = fan_ff;
    assign seq_state = state_ff;

endmodule
`default_nettype wire

// *** inc/drss_defines.svh ***
`ifndef DRSS_DEFINES_SVH
`define DRSS_DEFINES_SVH

// Register byte offsets
`define DRSS_OFS_CMD 12'h000
`define DRSS_OFS_DELAY 12'h004
`define DRSS_OFS_STATUS 12'h008

// Command register fields
`define DRSS_CMD_RESET 11'h238
`define DRSS_CMD_WIDTH 11

// Contactor delay in tenths of a second
`define DRSS_DELAY_WIDTH 7
`define DRSS_DELAY_DEFAULT 7'h64
`define DRSS_DELAY_MIN 7'h0A
`define DRSS_DELAY_MAX 7'h64

// Status register fields
`define DRSS_ST_STATE_LSB 0
`define DRSS_ST_STATE_MSB 2
`define DRSS_ST_WIDTH 15

// Timing
`define DRSS_CLK_MHZ 125
`define DRSS_EXEC_US 1000
`define DRSS_TICK_CYCLES (`DRSS_EXEC_US * `DRSS_CLK_MHZ)
`define DRSS_FAN_HOLD_S 60
`define DRSS_FAN_HOLD_TICKS (`DRSS_FAN_HOLD_S * 1000000 / `DRSS_EXEC_US)
`define DRSS_TICKS_PER_TENTH (100000 / `DRSS_EXEC_US)
`define DRSS_TMR_WIDTH 17

`endif

// *** inc/drss_pkg.sv ***
package drss_pkg;

    typedef enum logic [2:0] {
        DRSS_START_DISABLED = 3'b000,
        DRSS_START_ENABLED = 3'b001,
        DRSS_RUN_ACCEPTED_FLAG = 3'b010,
        DRSS_READY = 3'b011,
        DRSS_ENABLED = 3'b100,
        DRSS_QHALT_ACTIVE = 3'b101,
        DRSS_FAULT_ACTIVE = 3'b110,
        DRSS_FAULTED = 3'b111
    } drss_state_type;

    // Command register, bit 10 first
    typedef struct packed {
        logic autostart;
        logic clear_faults_on_run_edge;
        logic remote_fault_clear;
        logic dir_invert;
        logic remote_sel;
        logic freewheel_permit;
        logic quick_halt_permit;
        logic power_enable;
        logic jog;
        logic run_rev;
        logic run_fwd;
    } drss_cmd_type;

    // Plant-side inputs
    typedef struct packed {
        logic contactor_closed;
        logic deflux_done;
        logic halt_ramp_done;
        logic coast_done;
        logic stack_trip;
        logic heatsink_hot;
        logic ambient_hot;
        logic load_high;
    } drss_plant_type;

endpackage

// *** sim/drss_sequencer_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module drss_sequencer_sva
#(
    parameter int TICK_CYCLES = 4
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire drss_pkg::drss_plant_type plant,
    input wire logic contactor_drive,
    input wire logic stage_enable,
    input wire logic fast_halt_ramp,
    input wire logic system_reset_pulse,
    input wire logic direction_demand_out,
    input wire logic cooling_fan_request,
    input wire logic [2:0] seq_state
);
    import drss_pkg::*;
    logic [7:0] pulse_len_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pulse_len_ff <= 8'h00;
        else
            pulse_len_ff <= system_reset_pulse ? pulse_len_ff + 8'h01 : 8'h00;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PREADY_AFTER_SETUP:
        assert property (psel && !penable |=> pready) else $error("no answer after setup");
    AST_PREADY_ONE_CYCLE:
        assert property (pready |=> !pready) else $error("pready held too long");
    AST_ERR_WITH_READY:
        assert property (pslverr |-> pready) else $error("pslverr without pready");
    AST_UPPER_BITS_ZERO:
        assert property (pready |-> prdata[31:15] == 17'h0) else $error("upper read bits set");
    AST_CONTACTOR_STATES:
        assert property (contactor_drive == ($past(seq_state) inside {3'h2, 3'h3, 3'h4, 3'h5}))
        else $error("contactor drive disagrees with state");
    AST_HALT_RAMP_STATE:
        assert property (fast_halt_ramp == ($past(seq_state) == DRSS_QHALT_ACTIVE))
        else $error("halt ramp disagrees with state");
    AST_STAGE_IN_RUN:
        assert property (stage_enable |-> $past(seq_state) inside {3'h4, 3'h5})
        else $error("stage enabled outside run");
    AST_PULSE_ON_ENTRY:
        assert property ($rose(system_reset_pulse) |-> seq_state == DRSS_ENABLED
            && $past(seq_state) != DRSS_ENABLED) else $error("reset pulse without entry");
    AST_PULSE_LENGTH:
        assert property ($fell(system_reset_pulse) |-> pulse_len_ff == TICK_CYCLES)
        else $error("reset pulse length wrong");
    AST_READY_NEEDS_CLOSED:
        assert property (seq_state == DRSS_READY && $past(seq_state) == DRSS_RUN_ACCEPTED_FLAG
            |-> plant.contactor_closed) else $error("ready without contactor feedback");
    AST_ENABLED_FROM_READY:
        assert property (seq_state == DRSS_ENABLED && $past(seq_state) != DRSS_ENABLED
            |-> $past(seq_state) == DRSS_READY) else $error("enabled not entered from ready");
    AST_FAN_ON_HOT:
        assert property ((plant.heatsink_hot || plant.ambient_hot || plant.load_high)[*8]
            |-> cooling_fan_request) else $error("fan off while hot");
    COV_ENABLED: cover property (seq_state == DRSS_ENABLED);
    COV_FAULTED: cover property (seq_state == DRSS_FAULTED);
    COV_SLVERR: cover property (pslverr);
endmodule
bind drss_sequencer drss_sequencer_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .plant(plant),
    .contactor_drive(contactor_drive), .stage_enable(stage_enable),
    .fast_halt_ramp(fast_halt_ramp), .system_reset_pulse(system_reset_pulse),
    .direction_demand_out(direction_demand_out), .cooling_fan_request(cooling_fan_request),
    .seq_state(seq_state));
`default_nettype wire

// *** sim/drss_plant_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module drss_plant_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic contactor_drive,
    input wire logic fast_halt_ramp,
    input wire logic stage_enable,
    input wire logic no_close,
    input wire logic ramp_hold,
    input wire logic [2:0] hot,
    output var drss_pkg::drss_plant_type plant
);
    import drss_pkg::*;
    logic [1:0] close_cnt_ff;
    logic [1:0] ramp_cnt_ff;
    wire logic closing = contactor_drive && !no_close;
    wire logic ramping = fast_halt_ramp && !ramp_hold;
    // Closure and ramp end lag their demand, so the design must wait for them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            close_cnt_ff <= 2'h0;
            ramp_cnt_ff <= 2'h0;
        end
        else
        begin
            close_cnt_ff <= closing ? close_cnt_ff + {1'b0, close_cnt_ff != 2'h3} : 2'h0;
            ramp_cnt_ff <= ramping ? ramp_cnt_ff + {1'b0, ramp_cnt_ff != 2'h3} : 2'h0;
        end
    end
    assign plant = {close_cnt_ff == 2'h3, 1'b1, ramp_cnt_ff == 2'h3, !stage_enable, 1'b0, hot};
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import drss_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, contactor_drive, stage_enable, fast_halt_ramp;
    logic system_reset_pulse, direction_demand_out, cooling_fan_request;
    logic [2:0] seq_state;
    drss_plant_type plant;
    logic no_close = 1'b0;
    logic ramp_hold = 1'b0;
    logic [2:0] hot = 3'h0;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    always #4 pclk = ~pclk;
    drss_sequencer #(.TICK_CYCLES(4), .FAN_HOLD_TICKS(10), .TICKS_PER_TENTH(2)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .plant(plant), .contactor_drive(contactor_drive), .stage_enable(stage_enable),
        .fast_halt_ramp(fast_halt_ramp), .system_reset_pulse(system_reset_pulse),
        .direction_demand_out(direction_demand_out),
        .cooling_fan_request(cooling_fan_request), .seq_state(seq_state));
    drss_plant_model u_plant (.pclk(pclk), .presetn(presetn),
        .contactor_drive(contactor_drive), .fast_halt_ramp(fast_halt_ramp),
        .stage_enable(stage_enable), .no_close(no_close), .ramp_hold(ramp_hold),
        .hot(hot), .plant(plant));
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    // Reads compare under a mask; writes pass a zero mask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] m, input logic [31:0] e, input logic er);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the bench timeout ends this wait
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        chk(prdata & m, e, "read data");
        chk({31'h0, pslverr}, {31'h0, er}, "slave error");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_st(input logic [2:0] s);
        int n;
        n = 0;
        while (seq_state !== s && n < 400)
        begin
            @(posedge pclk);
            n++;
        end
        chk({29'h0, seq_state}, {29'h0, s}, "state");
    endtask
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            stop_test();
        end
    end
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({29'h0, seq_state}, 32'h0, "reset state");
        chk({28'h0, stage_enable, contactor_drive, fast_halt_ramp, system_reset_pulse}, 0, "flags");
        xfer(0, 12'h000, 0, 32'h7FF, 32'h238, 0);
        xfer(0, 12'h004, 0, 32'h7F, 32'h64, 0);
        xfer(0, 12'h008, 0, 32'hF8, 32'h80, 0);
        xfer(0, 12'h00C, 0, 32'hFFFFFFFF, 0, 1);
        xfer(1, 12'h008, 32'h7, 0, 0, 1);
        xfer(1, 12'h004, 32'h5, 0, 0, 0);
        xfer(0, 12'h004, 0, 32'h7F, 32'h0A, 0);
        xfer(1, 12'h000, 32'h278, 0, 0, 0);
        wait_st(DRSS_START_ENABLED);
        xfer(1, 12'h000, 32'h27B, 0, 0, 0);
        repeat (12) @(posedge pclk);
        chk({29'h0, seq_state}, 32'h1, "both directions ran");
        chk({31'h0, direction_demand_out}, 0, "direction with both");
        xfer(1, 12'h000, 32'h278, 0, 0, 0);
        repeat (8) @(posedge pclk);
        xfer(1, 12'h000, 32'h279, 0, 0, 0);
        wait_st(DRSS_RUN_ACCEPTED_FLAG);
        wait_st(DRSS_ENABLED);
        repeat (2) @(posedge pclk);
        chk({31'h0, system_reset_pulse}, 32'h1, "reset pulse");
        xfer(0, 12'h008, 0, 32'h208, 32'h008, 0);
        for (int i = 0; i < 2; i++)
        begin
            xfer(1, 12'h000, 32'h279 | (i << 7), 0, 0, 0);
            repeat (12) @(posedge pclk);
            chk({31'h0, direction_demand_out}, i, "direction");
        end
        ramp_hold <= 1'b1;
        xfer(1, 12'h000, 32'h269, 0, 0, 0);
        wait_st(DRSS_QHALT_ACTIVE);
        repeat (2) @(posedge pclk);
        chk({31'h0, fast_halt_ramp}, 32'h1, "halt ramp");
        xfer(1, 12'h000, 32'h279, 0, 0, 0);
        repeat (40) @(posedge pclk);
        chk({29'h0, seq_state}, 32'h5, "restart before ramp end");
        ramp_hold <= 1'b0;
        wait_st(DRSS_START_DISABLED);
        xfer(1, 12'h000, 32'h278, 0, 0, 0);
        repeat (8) @(posedge pclk);
        xfer(1, 12'h000, 32'h279, 0, 0, 0);
        wait_st(DRSS_ENABLED);
        xfer(1, 12'h000, 32'h259, 0, 0, 0);
        repeat (12) @(posedge pclk);
        chk({31'h0, stage_enable}, 0, "stage after coast");
        xfer(1, 12'h000, 32'h278, 0, 0, 0);
        wait_st(DRSS_START_ENABLED);
        no_close <= 1'b1;
        xfer(1, 12'h000, 32'h279, 0, 0, 0);
        wait_st(DRSS_RUN_ACCEPTED_FLAG);
        xfer(0, 12'h008, 0, 32'h900, 32'h900, 0);
        repeat (50) @(posedge pclk);
        chk({29'h0, seq_state}, 32'h2, "contactor trip early");
        wait_st(DRSS_FAULTED);
        xfer(0, 12'h008, 0, 32'h40C0, 32'h4040, 0);
        xfer(1, 12'h000, 32'h278, 0, 0, 0);
        repeat (12) @(posedge pclk);
        xfer(0, 12'h008, 0, 32'hC0, 32'hC0, 0);
        xfer(1, 12'h000, 32'h378, 0, 0, 0);
        wait_st(DRSS_START_ENABLED);
        xfer(1, 12'h000, 32'h379, 0, 0, 0);
        wait_st(DRSS_FAULTED);
        repeat (20) @(posedge pclk);
        chk({29'h0, seq_state}, 32'h7, "steady clear level");
        no_close <= 1'b0;
        xfer(1, 12'h000, 32'h378, 0, 0, 0);
        repeat (12) @(posedge pclk);
        xfer(1, 12'h000, 32'h379, 0, 0, 0);
        repeat (12) @(posedge pclk);
        xfer(0, 12'h008, 0, 32'h40, 32'h0, 0);
        hot <= 3'h4;
        repeat (12) @(posedge pclk);
        chk({31'h0, cooling_fan_request}, 32'h1, "fan on");
        hot <= 3'h0;
        repeat (24) @(posedge pclk);
        chk({31'h0, cooling_fan_request}, 32'h1, "fan hold");
        repeat (40) @(posedge pclk);
        chk({31'h0, cooling_fan_request}, 0, "fan off");
        // Second power-up: autostart must run without a new run edge
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1, 12'h000, 32'h679, 0, 0, 0);
        wait_st(DRSS_READY);
        xfer(0, 12'h008, 0, 32'h200, 32'h200, 0);
        wait_st(DRSS_ENABLED);
        stop_test();
    end
endmodule
`default_nettype wire
